// ===== arsc_cfg.svh
// register map, field positions and reset values for reference select
//------------------------------------------------------------------------
// Contract
// - high select bit at bit 7, joins low bit
// - code 00 selects external reference pin
// - code 01 enables internal 1.0 V reference
// - code 10 selects 2.0 V, reset default
// - independent of comparator reference setting
// - input select codes 0-7 pick inputs
// - reserved input code opens all switches
//------------------------------------------------------------------------
`ifndef ARSC_CFG_SVH
`define ARSC_CFG_SVH

// register indices; byte address is four times the index
`define ARSC_IDX_CTL0      14'h0f70
`define ARSC_IDX_CTL1      14'h0f71
`define ARSC_IDX_STAT      14'h0f7f

// reset values
`define ARSC_RST_CTL0      8'h00
`define ARSC_RST_CTL1      8'h80
// reference lines {int_en, ext_sel, lvl_2v}: internal on at 2.0 V
`define ARSC_RST_REF       3'h5

// field positions
`define ARSC_BIT_SEL_HI    7
`define ARSC_BIT_SEL_LO    4
`define ARSC_AIN_MSB       3
`define ARSC_AIN_LSB       0

// status register layout
`define ARSC_ST_CODE_MSB   1
`define ARSC_ST_CODE_LSB   0
`define ARSC_ST_INT_EN     2
`define ARSC_ST_EXT_SEL    3
`define ARSC_ST_LVL_2V     4
`define ARSC_ST_AIN_OPEN   5

`endif

// ===== arsc_pkg.sv
// types shared by the reference select block
package arsc_pkg;

  // two-bit reference code {hi, lo}
  typedef enum logic [1:0] {
    ARSC_REF_EXT = 2'h0,   // internal off, external pin
    ARSC_REF_1V0 = 2'h1,   // internal 1.0 V
    ARSC_REF_2V0 = 2'h2,   // internal 2.0 V
    ARSC_REF_RSV = 2'h3    // undocumented combination
  } arsc_ref_e;

  // analog reference controls toward the converter
  typedef struct packed {
    logic int_en;          // internal reference powered
    logic ext_sel;         // reference taken from the pin
    logic lvl_2v;          // internal level 2.0 V, else 1.0 V
  } arsc_ref_s;

endpackage : arsc_pkg

// ===== arsc_ref_decode.sv
// combinational decode of reference code and analog input select
`timescale 1ns/10ps
module arsc_ref_decode
  import arsc_pkg::*;
#(
  parameter int NUM_INPUTS = 8     // analog inputs behind the selector
) (
  // codes from the control registers
  input  wire arsc_ref_e             ref_code_i,
  input  wire logic [3:0]            ain_code_i,
  // decoded analog controls
  output arsc_ref_s                  ref_ctl_o,
  output logic [NUM_INPUTS-1:0]      ain_switch_o,
  output logic                       ain_open_o
);

  //----------------------------------------------------------------------
  // reference decode
  //----------------------------------------------------------------------
  // only the converter's own code is looked at, never the comparator's
  always_comb begin
    ref_ctl_o = '0;
    case (ref_code_i)
      ARSC_REF_EXT: ref_ctl_o.ext_sel = 1'b1;
      ARSC_REF_1V0: ref_ctl_o.int_en  = 1'b1;
      ARSC_REF_2V0: begin
        ref_ctl_o.int_en = 1'b1;
        ref_ctl_o.lvl_2v = 1'b1;
      end
      // undocumented 11: kept on the 2.0 V level, pin unused
      default: begin
        ref_ctl_o.int_en = 1'b1;
        ref_ctl_o.lvl_2v = 1'b1;
      end
    endcase
  end

  //----------------------------------------------------------------------
  // analog input switches
  //----------------------------------------------------------------------
  // any code at or beyond the input count opens every switch
  assign ain_open_o = ({28'h0, ain_code_i} >= NUM_INPUTS);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_sw
      // one switch per input, closed only for its own code
      assign ain_switch_o[gi] = ({28'h0, ain_code_i} == gi);
    end
  endgenerate

endmodule : arsc_ref_decode

// ===== arsc_top.sv
// wishbone register file and registered reference/input controls
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/10ps
`include "arsc_cfg.svh"
module arsc_top
  import arsc_pkg::*;
#(
  parameter int NUM_INPUTS = 8     // analog inputs behind the selector
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone slave
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [15:0]           adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic [31:0]                dat_o,
  output logic                       ack_o,
  // reference controls toward the converter
  output arsc_ref_s                  ref_ctl_o,
  // analog input selector
  output logic [NUM_INPUTS-1:0]      ain_switch_o,
  output logic                       ain_open_o
);

  //----------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------
  // word index match, used for every register
  function automatic logic arsc_hit(input logic [15:0] adr,
                                    input logic [13:0] idx);
    arsc_hit = (adr[15:2] == idx);
  endfunction : arsc_hit

  //----------------------------------------------------------------------
  // declarations
  //----------------------------------------------------------------------
  logic [7:0]            ctl0_q, ctl0_d;   // low select and input code
  logic [7:0]            ctl1_q, ctl1_d;   // reference control register
  logic                  ack_q, ack_d;     // bus acknowledge
  logic [31:0]           dat_q, dat_d;     // read data
  arsc_ref_s             ref_q, ref_d;     // registered reference lines
  logic [NUM_INPUTS-1:0] sw_q, sw_d;       // registered switches
  logic                  open_q, open_d;   // all switches open
  logic                  req;              // new access this cycle
  logic                  wr_en;            // write to lane 0
  arsc_ref_e             ref_code;         // joined reference code
  logic [7:0]            stat;             // live status byte

  // a request is taken once; ack_q blocks the repeat cycle
  assign req   = cyc_i & stb_i & ~ack_q;
  assign wr_en = req & we_i & sel_i[0];

  // high bit of the reference register joins the low bit
  assign ref_code = arsc_ref_e'({ctl1_q[`ARSC_BIT_SEL_HI],
                                 ctl0_q[`ARSC_BIT_SEL_LO]});

  //----------------------------------------------------------------------
  // decoder
  //----------------------------------------------------------------------
  arsc_ref_decode #(
    .NUM_INPUTS (NUM_INPUTS)
  ) u_dec (
    .ref_code_i   (ref_code),
    .ain_code_i   (ctl0_q[`ARSC_AIN_MSB:`ARSC_AIN_LSB]),
    .ref_ctl_o    (ref_d),
    .ain_switch_o (sw_d),
    .ain_open_o   (open_d)
  );

  //----------------------------------------------------------------------
  // control registers
  //----------------------------------------------------------------------
  // next values of both control registers
  always_comb begin
    ctl0_d = ctl0_q;
    ctl1_d = ctl1_q;
    if (wr_en && arsc_hit(adr_i, `ARSC_IDX_CTL0)) begin
      ctl0_d = dat_i[7:0];
    end
    // all eight bits stored, reserved ones too, for readback
    if (wr_en && arsc_hit(adr_i, `ARSC_IDX_CTL1)) begin
      ctl1_d = dat_i[7:0];
    end
  end

  // register stage; reset leaves the 2.0 V default selected
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl0_q <= `ARSC_RST_CTL0;
      ctl1_q <= `ARSC_RST_CTL1;
    end else begin
      ctl0_q <= ctl0_d;
      ctl1_q <= ctl1_d;
    end
  end

  //----------------------------------------------------------------------
  // bus answer
  //----------------------------------------------------------------------
  // status byte shows the joined register code and the registered reference and input lines actually driven
  always_comb begin
    stat = 8'h00;
    stat[`ARSC_ST_CODE_MSB:`ARSC_ST_CODE_LSB] = ref_code;
    stat[`ARSC_ST_INT_EN]   = ref_q.int_en;
    stat[`ARSC_ST_EXT_SEL]  = ref_q.ext_sel;
    stat[`ARSC_ST_LVL_2V]   = ref_q.lvl_2v;
    stat[`ARSC_ST_AIN_OPEN] = open_q;
  end

  // one-cycle answer; unmapped reads give zero, writes are dropped
  always_comb begin
    ack_d = req;
    dat_d = 32'h0;
    if (req && !we_i) begin
      if (arsc_hit(adr_i, `ARSC_IDX_CTL0)) begin
        dat_d = {24'h0, ctl0_q};
      end else if (arsc_hit(adr_i, `ARSC_IDX_CTL1)) begin
        dat_d = {24'h0, ctl1_q};
      end else if (arsc_hit(adr_i, `ARSC_IDX_STAT)) begin
        dat_d = {24'h0, stat};
      end else begin
        dat_d = 32'h0;
      end
    end
  end

  // bus output registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  //----------------------------------------------------------------------
  // analog control outputs
  //----------------------------------------------------------------------
  // registered so the analog side never sees decode glitches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_q  <= arsc_ref_s'(`ARSC_RST_REF);
      sw_q   <= '0;
      open_q <= 1'b0;
    end else begin
      ref_q  <= ref_d;
      sw_q   <= sw_d;
      open_q <= open_d;
    end
  end

  assign ack_o        = ack_q;
  assign dat_o        = dat_q;
  assign ref_ctl_o    = ref_q;
  assign ain_switch_o = sw_q;
  assign ain_open_o   = open_q;

  //----------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // write to the reference register lands at ack
  AST_HI_WRITE: assert property (
    wr_en && arsc_hit(adr_i, `ARSC_IDX_CTL1)
      |=> ctl1_q == $past(dat_i[7:0]) && ack_o)
    else $error("reference register write lost");

  // code 00 gives the pin, internal off, one cycle later
  AST_EXT_PIN: assert property (
    ref_code == ARSC_REF_EXT
      |=> ref_ctl_o.ext_sel && !ref_ctl_o.int_en)
    else $error("external reference not selected");

  // code 01 gives internal at 1.0 V
  AST_ONE_VOLT: assert property (
    ref_code == ARSC_REF_1V0
      |=> ref_ctl_o.int_en && !ref_ctl_o.lvl_2v && !ref_ctl_o.ext_sel)
    else $error("1.0 V reference not selected");

  // code 10 gives internal at 2.0 V
  AST_TWO_VOLT: assert property (
    ref_code == ARSC_REF_2V0
      |=> ref_ctl_o.int_en && ref_ctl_o.lvl_2v && !ref_ctl_o.ext_sel)
    else $error("2.0 V reference not selected");

  // reset leaves the 2.0 V default in place
  AST_RESET_DEFAULT: assert property (disable iff (1'b0)
    rst_i |=> ctl1_q == `ARSC_RST_CTL1 && ref_ctl_o.lvl_2v)
    else $error("reference default wrong after reset");

  // accesses outside the reference register leave it alone
  AST_INDEPENDENT: assert property (
    req && !arsc_hit(adr_i, `ARSC_IDX_CTL1) |=> $stable(ctl1_q))
    else $error("reference register changed by other access");

  // a valid input code closes exactly its own switch
  AST_AIN_SELECT: assert property (
    {28'h0, ctl0_q[3:0]} < NUM_INPUTS
      |=> ain_switch_o == NUM_INPUTS'(1) << $past(ctl0_q[3:0])
          && !ain_open_o)
    else $error("input switch mismatch");

  // a reserved input code opens every switch
  AST_AIN_OPEN: assert property (
    {28'h0, ctl0_q[3:0]} >= NUM_INPUTS
      |=> ain_switch_o == '0 && ain_open_o)
    else $error("switches not opened for reserved code");

  // read of the reference register returns the stored byte
  AST_READBACK: assert property (
    req && !we_i && arsc_hit(adr_i, `ARSC_IDX_CTL1)
      |=> ack_o && dat_o == {24'h0, $past(ctl1_q)})
    else $error("reference register readback wrong");

  // ack is a single pulse per access
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");

  // main scenarios
  COV_WRITE_REF: cover property (wr_en && arsc_hit(adr_i, `ARSC_IDX_CTL1));
  COV_ONE_VOLT:  cover property (ref_code == ARSC_REF_1V0 ##1 ref_q.int_en);
  COV_EXT_PIN:   cover property (ref_ctl_o.ext_sel);
  COV_AIN_OPEN:  cover property (ain_open_o);

endmodule : arsc_top

// ===== tb_arsc.sv
// self-checking bench for the reference select register block
`timescale 1ns/10ps
`include "arsc_cfg.svh"
module tb;
  import arsc_pkg::*;
  //----------------------------------------------------------------------
  // signals and counters
  //----------------------------------------------------------------------
  logic                clk_i;           // 40 mhz system clock
  logic                rst_i;           // synchronous reset, active high
  logic                cyc_i;           // wishbone cycle
  logic                stb_i;           // wishbone strobe
  logic                we_i;            // write enable
  logic [15:0]         adr_i;           // byte address
  logic [3:0]          sel_i;           // byte enables
  logic [31:0]         dat_i;           // write data
  logic [31:0]         dat_o;           // read data
  logic                ack_o;           // access acknowledge
  arsc_ref_s           ref_ctl_o;       // reference controls
  logic [7:0]          ain_switch_o;    // one-hot input switches
  logic                ain_open_o;      // all switches open
  int                  error_cnt;       // mismatches seen
  int                  samples_checked; // comparisons made
  //----------------------------------------------------------------------
  // clock and device under test
  //----------------------------------------------------------------------
  always #12.5 clk_i = ~clk_i;
  arsc_top #(.NUM_INPUTS(8)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .ref_ctl_o(ref_ctl_o),
    .ain_switch_o(ain_switch_o), .ain_open_o(ain_open_o)
  );
  //----------------------------------------------------------------------
  // closing, comparison and bus tasks
  //----------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  // any four-state mismatch counts, unknowns never pass
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [13:0] idx,
                    input logic [7:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'h0};
    sel_i <= s;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    // bounded wait: a missing ack ends the run
    if (ack_o !== 1'b1) begin
      error_cnt++;
      report_and_stop();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, 4'hf, q);
  endtask : wr

  // upper read bits must always be zero
  task automatic rd(input string nm, input logic [13:0] idx,
                    input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, idx, 8'h00, 4'hf, q);
    chk(nm, {24'h0, e}, q);
  endtask : rd
  //----------------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------------
  initial begin
    logic [31:0] q;
    clk_i = 1'b0;
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i  = 1'b0;
    adr_i = 16'h0000;
    sel_i = 4'h0;
    dat_i = 32'h0000_0000;
    error_cnt = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset defaults: 2.0 v internal, input zero selected
    repeat (2) @(posedge clk_i);
    chk("ref_ctl", 32'h5, 32'(ref_ctl_o));
    chk("ain_switch", 32'h1, 32'(ain_switch_o));
    chk("ain_open", 32'h0, 32'(ain_open_o));
    rd("ctl1", `ARSC_IDX_CTL1, 8'h80);
    rd("ctl0", `ARSC_IDX_CTL0, 8'h00);
    rd("status", `ARSC_IDX_STAT, 8'h16);
    $display("test reset done");
    // every reference code, high bit from ctl1, low bit from ctl0
    for (int c = 0; c < 4; c++) begin
      wr(`ARSC_IDX_CTL1, {c[1], 7'h00});
      wr(`ARSC_IDX_CTL0, {3'h0, c[0], 4'h0});
      @(posedge clk_i);
      chk("int_en", 32'(c != 0), 32'(ref_ctl_o.int_en));
      chk("ext_sel", 32'(c == 0), 32'(ref_ctl_o.ext_sel));
      // level only matters while the internal source is on
      if (c != 0) begin
        chk("lvl_2v", 32'(c[1]), 32'(ref_ctl_o.lvl_2v));
      end
      rd("ctl1", `ARSC_IDX_CTL1, {c[1], 7'h00});
    end
    $display("test reference codes done");
    // all sixteen input codes, each checked one clock after its own write
    wr(`ARSC_IDX_CTL1, 8'h80);
    for (int a = 0; a < 16; a++) begin
      wr(`ARSC_IDX_CTL0, {4'h0, a[3:0]});
      @(posedge clk_i);
      chk("ain_switch", (a < 8) ? (32'h1 << a) : 32'h0,
          32'(ain_switch_o));
      chk("ain_open", 32'(a >= 8), 32'(ain_open_o));
      chk("ref_ctl", 32'h5, 32'(ref_ctl_o));
    end
    $display("test input select done");
    // reserved bits written as zeros; masked and unmapped writes ignored
    wr(`ARSC_IDX_CTL1, 8'h00);
    rd("ctl1", `ARSC_IDX_CTL1, 8'h00);
    @(posedge clk_i);
    chk("ext_sel", 32'h1, 32'(ref_ctl_o.ext_sel));
    wb(1'b1, `ARSC_IDX_CTL1, 8'h80, 4'h0, q);
    rd("ctl1", `ARSC_IDX_CTL1, 8'h00);
    wr(14'h0f72, 8'hff);
    rd("unmapped", 14'h0f72, 8'h00);
    rd("ctl1", `ARSC_IDX_CTL1, 8'h00);
    $display("test readback done");
    // mid-run reset must bring back the 2.0 v default and input zero
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("ref_ctl", 32'h5, 32'(ref_ctl_o));
    chk("ain_switch", 32'h1, 32'(ain_switch_o));
    chk("ain_open", 32'h0, 32'(ain_open_o));
    rd("ctl1", `ARSC_IDX_CTL1, 8'h80);
    rd("ctl0", `ARSC_IDX_CTL0, 8'h00);
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule : tb
